/* File: cpu_mul_regs.svh */
// register offsets, status bit positions, reset values and cycle counts
`ifndef CPU_MUL_REGS_SVH
`define CPU_MUL_REGS_SVH
`define OFF_WORKING_REG_ZERO_LAST 5'h0F
`define OFF_STATUS    5'h10
`define OFF_ACCA_LO   5'h11
`define OFF_ACCA_HI   5'h12
`define OFF_ACCA_UP   5'h13
`define OFF_ACCB_LO   5'h14
`define OFF_ACCB_HI   5'h15
`define OFF_ACCB_UP   5'h16
`define OFF_PC        5'h17
`define OFF_CYCLES    5'h18
`define BIT_C         0
`define BIT_Z         1
`define BIT_OV        2
`define BIT_N         3
`define BIT_DC        8
`define BIT_SB        12
`define BIT_SA        13
`define BIT_OB        14
`define BIT_OA        15
`define STATUS_RST    16'h0000
`define PC_RST        16'h0000
`define PC_STEP       16'h0002
`define AWB_REG       4'hD
`define AWB_STEP      16'h0002
`define EXTRA_CYCLES  2'h1
`endif

/* File: cpu_mul_pkg.sv */
// types for the multiply core: instruction word, sequencer states, bus carriers
package cpu_mul_pkg;
  typedef enum logic [1:0] {SM_SS = 2'h0, SM_SU = 2'h1, SM_US = 2'h2, SM_UU = 2'h3} sign_mode_t;
  typedef enum logic [1:0] {SZ_WORD = 2'h0, SZ_BYTE = 2'h1, SZ_DOUBLE = 2'h2} size_t;
  typedef enum logic [5:0] {
    OC_NOP = 6'h00, OC_MULF = 6'h01, OC_PRODUCT_OP_LOW_WORD = 6'h02, OC_MULA = 6'h03,
    OC_SKPZ = 6'h08, OC_BRA = 6'h09, OC_SLOWRD = 6'h0A, OC_MOVD = 6'h0B,
    OC_BSET = 6'h0C, OC_ASHF = 6'h0D, OC_AWB = 6'h0E, OC_ADD = 6'h0F
  } op_class_t;
  typedef enum logic [1:0] {ST_RUN = 2'h0, ST_WORD2 = 2'h1, ST_STALL = 2'h2} seq_state_t;
  typedef struct packed {
    op_class_t  cls;
    logic [1:0] mode;
    logic       acc;
    logic       awbInd;
    logic       lit;
    logic [3:0] dst;
    logic [4:0] src;
    logic [3:0] base;
  } instr_t;
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [4:0]  addr;
    logic [15:0] data;
  } reg_req_t;
  typedef struct packed {
    logic        en;
    logic [15:0] addr;
    logic [15:0] data;
  } mem_wr_t;
endpackage

/* File: cpu_mul_core.sv */
// multiply datapath with instruction cycle sequencer
// What this block does
// [RULE_01] single words are 24 bits, 8-bit opcode
// [RULE_02] double word spans 48 bits, second upper zero
// [RULE_03] lone second word executes as no-op
// [RULE_04] double-word instructions take exactly two cycles
// [RULE_05] single word one cycle, extras for listed cases
// [RULE_06] extra cycles change no architectural state
// [RULE_07] taken skip costs two or three cycles
// [RULE_08] full product fills register pair, low first
// [RULE_09] four sign modes choose operand interpretation
// [RULE_10] low-word form writes one 16-bit register
// [RULE_11] multiply may load a selected accumulator
// [RULE_12] short literal operand is always unsigned
// [RULE_13] multiply: one word, one cycle, flags kept
// [RULE_14] word default, byte and double selectors
// [RULE_15] two accumulators, each op names one
// [RULE_16] writeback to W13 or [W13] post-increment
// [RULE_17] C, DC, N, OV and sticky Z kept
// [RULE_18] overflow and saturation bit per accumulator
// [RULE_19] 4-bit field picks bit 0 to 15
// [RULE_20] shift amount from register or literal
//
// Decided for this implementation: the address map and the strobed register port.
`include "cpu_mul_regs.svh"
module cpu_mul_core (
  input  wire logic                  clock,
  input  wire logic                  rstn,
  input  wire cpu_mul_pkg::reg_req_t regReq,
  output logic [15:0]                regRdData,
  input  wire logic                  instrValid,
  input  wire logic [23:0]           instrWord,
  output logic                       instrReady,
  output logic                       retirePulse,
  output logic [15:0]                pcOut,
  output cpu_mul_pkg::mem_wr_t       memWr
);
  cpu_mul_pkg::instr_t     ins;
  cpu_mul_pkg::seq_state_t state_r;
  cpu_mul_pkg::seq_state_t state_nxt;
  cpu_mul_pkg::mem_wr_t    mem_r;
  logic [15:0] w_r [16];
  logic [39:0] acc_r [2];
  logic        c_r, dc_r, n_r, ov_r, z_r;
  logic [1:0]  accOv_r;
  logic [1:0]  accSat_r;
  logic        skip_r, dw2Drop_r, ready_r, retire_r;
  logic [3:0]  dw2Dst_r;
  logic [1:0]  stallCnt_r;
  logic [15:0] pc_r, cyc_r, rd_r, rd_nxt, statusWord;
  logic        take, exec, isMul, multiCyc;
  logic [15:0] opA, opB;
  logic [32:0] prod;
  logic [39:0] accSel;

  // [RULE_01] opcode byte on top of the fetched word
  assign ins        = cpu_mul_pkg::instr_t'(instrWord);
  assign take       = instrValid && ready_r;
  assign exec       = take && state_r == cpu_mul_pkg::ST_RUN && !skip_r;
  // [RULE_13] multiply forms retire in one cycle, flags untouched
  assign isMul      = ins.cls inside {cpu_mul_pkg::OC_MULF, cpu_mul_pkg::OC_PRODUCT_OP_LOW_WORD, cpu_mul_pkg::OC_MULA};
  assign multiCyc   = ins.cls inside {cpu_mul_pkg::OC_MOVD, cpu_mul_pkg::OC_BRA, cpu_mul_pkg::OC_SLOWRD};
  // [RULE_15] the accumulator field names exactly one of two
  assign accSel     = acc_r[ins.acc];
  assign instrReady = ready_r;
  assign retirePulse = retire_r;
  assign pcOut      = pc_r;
  assign memWr      = mem_r;
  assign regRdData  = rd_r;

  function automatic logic [32:0] mulProd(input logic [15:0] a, input logic [15:0] b,
                                          input logic sa, input logic sb);
    logic signed [16:0] ea;
    logic signed [16:0] eb;
    logic signed [33:0] p;
    ea = {sa & a[15], a};
    eb = {sb & b[15], b};
    p  = ea * eb;
    return p[32:0];
  endfunction

  // [RULE_12] a literal operand is zero-extended and never signed
  assign opA  = w_r[ins.base];
  assign opB  = ins.lit ? {11'h000, ins.src} : w_r[ins.src[3:0]];
  // [RULE_09] mode bits pick the reading of base and source
  assign prod = mulProd(opA, opB, ins.mode inside {cpu_mul_pkg::SM_SS, cpu_mul_pkg::SM_SU},
                        ins.mode inside {cpu_mul_pkg::SM_SS, cpu_mul_pkg::SM_US} && !ins.lit);

  // adder shifts operands so the selected width's msb sits at bit 31
  logic [4:0]  sh;
  logic        dbl;
  logic [31:0] addA, addB, shA, shB, addRes;
  logic [32:0] addSum;
  logic [4:0]  nib;
  always_comb begin
    dbl = ins.mode == cpu_mul_pkg::SZ_DOUBLE;
    // [RULE_14] byte, word or double operand width
    case (ins.mode)
      cpu_mul_pkg::SZ_BYTE:   sh = 5'h18;
      cpu_mul_pkg::SZ_DOUBLE: sh = 5'h00;
      default:                sh = 5'h10;
    endcase
    addA   = dbl ? {w_r[ins.base + 4'h1], w_r[ins.base]} : {16'h0000, w_r[ins.base]};
    addB   = dbl ? {w_r[ins.src[3:0] + 4'h1], w_r[ins.src[3:0]]} : {16'h0000, w_r[ins.src[3:0]]};
    shA    = addA << sh;
    shB    = addB << sh;
    addSum = {1'b0, shA} + {1'b0, shB};
    addRes = addSum[31:0] >> sh;
    nib    = {1'b0, addA[3:0]} + {1'b0, addB[3:0]};
  end

  logic [4:0]  amt;
  logic [71:0] shl;
  logic        shOvf, guardOvf;
  logic [39:0] shAcc;
  always_comb begin
    // [RULE_20] shift count from a working register or the literal
    amt      = ins.lit ? ins.src : w_r[ins.src[3:0]][4:0];
    shl      = {{32{accSel[39]}}, accSel} << amt;
    shOvf    = shl[71:39] != {33{accSel[39]}};
    guardOvf = shl[39:31] != {9{shl[31]}};
    shAcc    = shOvf ? (accSel[39] ? 40'h80_0000_0000 : 40'h7F_FFFF_FFFF) : shl[39:0];
  end

  always_comb begin
    statusWord            = 16'h0000;
    statusWord[`BIT_C]    = c_r;
    statusWord[`BIT_Z]    = z_r;
    statusWord[`BIT_OV]   = ov_r;
    statusWord[`BIT_N]    = n_r;
    statusWord[`BIT_DC]   = dc_r;
    statusWord[`BIT_OA]   = accOv_r[0];
    statusWord[`BIT_OB]   = accOv_r[1];
    statusWord[`BIT_SA]   = accSat_r[0];
    statusWord[`BIT_SB]   = accSat_r[1];
  end

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      cpu_mul_pkg::ST_RUN: begin
        // [RULE_02] a double-word opcode waits for its second word
        if (take && ins.cls == cpu_mul_pkg::OC_MOVD) begin
          state_nxt = cpu_mul_pkg::ST_WORD2;
        // [RULE_05] flow change or slow read adds a cycle
        end else if (exec && multiCyc) begin
          state_nxt = cpu_mul_pkg::ST_STALL;
        end
      end
      cpu_mul_pkg::ST_WORD2: if (take) begin
        state_nxt = cpu_mul_pkg::ST_RUN;
      end
      cpu_mul_pkg::ST_STALL: if (stallCnt_r == 2'h1) begin
        state_nxt = cpu_mul_pkg::ST_RUN;
      end
      default: state_nxt = cpu_mul_pkg::ST_RUN;
    endcase
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_r    <= cpu_mul_pkg::ST_RUN;
      ready_r    <= 1'b1;
      stallCnt_r <= 2'h0;
      skip_r     <= 1'b0;
      dw2Drop_r  <= 1'b0;
      dw2Dst_r   <= 4'h0;
      retire_r   <= 1'b0;
    end else begin
      state_r <= state_nxt;
      // [RULE_06] stall cycles take no word and write nothing
      ready_r <= state_nxt != cpu_mul_pkg::ST_STALL;
      if (state_nxt == cpu_mul_pkg::ST_STALL && state_r != cpu_mul_pkg::ST_STALL) begin
        stallCnt_r <= `EXTRA_CYCLES;
      end else if (stallCnt_r != 2'h0) begin
        stallCnt_r <= stallCnt_r - 2'h1;
      end
      // [RULE_07] skipped word dropped, and its second word too
      if (take && state_r == cpu_mul_pkg::ST_RUN) begin
        dw2Dst_r <= ins.dst;
        if (skip_r) begin
          skip_r    <= 1'b0;
          dw2Drop_r <= ins.cls == cpu_mul_pkg::OC_MOVD;
        end else begin
          skip_r    <= ins.cls == cpu_mul_pkg::OC_SKPZ && opA == 16'h0000;
          dw2Drop_r <= 1'b0;
        end
      end
      // [RULE_04] a double word retires when its second word lands
      retire_r <= (exec && !multiCyc) ||
                  (state_r == cpu_mul_pkg::ST_STALL && state_nxt == cpu_mul_pkg::ST_RUN) ||
                  (take && state_r == cpu_mul_pkg::ST_WORD2 && !dw2Drop_r);
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pc_r  <= `PC_RST;
      cyc_r <= 16'h0000;
      mem_r <= '0;
    end else begin
      cyc_r <= cyc_r + 16'h0001;
      if (exec && ins.cls == cpu_mul_pkg::OC_BRA) begin
        pc_r <= opA;
      end else if (take) begin
        pc_r <= pc_r + `PC_STEP;
      end
      // [RULE_16] indirect writeback stores at the pointer register
      mem_r.en   <= exec && ins.cls == cpu_mul_pkg::OC_AWB && ins.awbInd;
      mem_r.addr <= w_r[`AWB_REG];
      mem_r.data <= accSel[31:16];
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < 16; i++) begin
        w_r[i] <= 16'h0000;
      end
    end else begin
      if (regReq.wr && regReq.addr <= `OFF_WORKING_REG_ZERO_LAST) begin
        w_r[regReq.addr[3:0]] <= regReq.data;
      end
      // [RULE_02] low 16 bits of the second word are the payload
      if (take && state_r == cpu_mul_pkg::ST_WORD2 && !dw2Drop_r) begin
        w_r[dw2Dst_r] <= instrWord[15:0];
      end
      if (exec) begin
        case (ins.cls)
          // [RULE_08] low half to the named register, high to the next
          cpu_mul_pkg::OC_MULF: begin
            w_r[ins.dst]        <= prod[15:0];
            w_r[ins.dst + 4'h1] <= prod[31:16];
          end
          // [RULE_10] only the low 16 bits, one register
          cpu_mul_pkg::OC_PRODUCT_OP_LOW_WORD: w_r[ins.dst] <= prod[15:0];
          cpu_mul_pkg::OC_ADD: begin
            if (ins.mode == cpu_mul_pkg::SZ_BYTE) begin
              w_r[ins.dst][7:0] <= addRes[7:0];
            end else begin
              w_r[ins.dst] <= addRes[15:0];
            end
            if (dbl) begin
              w_r[ins.dst + 4'h1] <= addRes[31:16];
            end
          end
          // [RULE_19] four-bit position picks one of sixteen bits
          cpu_mul_pkg::OC_BSET:   w_r[ins.base][ins.src[3:0]] <= 1'b1;
          cpu_mul_pkg::OC_SLOWRD: w_r[ins.dst] <= statusWord;
          // [RULE_16] direct store, or pointer bumped by two
          cpu_mul_pkg::OC_AWB: begin
            if (ins.awbInd) begin
              w_r[`AWB_REG] <= w_r[`AWB_REG] + `AWB_STEP;
            end else begin
              w_r[`AWB_REG] <= accSel[31:16];
            end
          end
          // [RULE_03] a lone payload word is class zero, no effect
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      acc_r[0] <= 40'h00_0000_0000;
      acc_r[1] <= 40'h00_0000_0000;
    end else begin
      case (regReq.wr ? regReq.addr : 5'h00)
        `OFF_ACCA_LO: acc_r[0][15:0]  <= regReq.data;
        `OFF_ACCA_HI: acc_r[0][31:16] <= regReq.data;
        `OFF_ACCA_UP: acc_r[0][39:32] <= regReq.data[7:0];
        `OFF_ACCB_LO: acc_r[1][15:0]  <= regReq.data;
        `OFF_ACCB_HI: acc_r[1][31:16] <= regReq.data;
        `OFF_ACCB_UP: acc_r[1][39:32] <= regReq.data[7:0];
        default: ;
      endcase
      // [RULE_11] product sign-extended into the chosen accumulator
      if (exec && ins.cls == cpu_mul_pkg::OC_MULA) begin
        acc_r[ins.acc] <= {{7{prod[32]}}, prod};
      end
      if (exec && ins.cls == cpu_mul_pkg::OC_ASHF) begin
        acc_r[ins.acc] <= shAcc;
      end
    end
  end

  // flags written after the bus so a hardware set beats a clear
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      {c_r, dc_r, n_r, ov_r, z_r} <= 5'h00;
      accOv_r  <= 2'h0;
      accSat_r <= 2'h0;
    end else begin
      if (regReq.wr && regReq.addr == `OFF_STATUS) begin
        c_r         <= regReq.data[`BIT_C];
        z_r         <= regReq.data[`BIT_Z];
        ov_r        <= regReq.data[`BIT_OV];
        n_r         <= regReq.data[`BIT_N];
        dc_r        <= regReq.data[`BIT_DC];
        accOv_r     <= {regReq.data[`BIT_OB], regReq.data[`BIT_OA]};
        accSat_r    <= {regReq.data[`BIT_SB], regReq.data[`BIT_SA]};
      end
      // [RULE_17] double adds only clear Z, so it stays sticky
      if (exec && ins.cls == cpu_mul_pkg::OC_ADD) begin
        c_r  <= addSum[32];
        dc_r <= nib[4];
        n_r  <= addSum[31];
        ov_r <= shA[31] == shB[31] && addSum[31] != shA[31];
        z_r  <= dbl ? z_r && addSum[31:0] == 32'h0000_0000 : addSum[31:0] == 32'h0000_0000;
      end
      // [RULE_18] per-accumulator overflow and sticky saturation
      if (exec && ins.cls == cpu_mul_pkg::OC_ASHF) begin
        accOv_r[ins.acc] <= guardOvf || shOvf;
        if (shOvf) begin
          accSat_r[ins.acc] <= 1'b1;
        end
      end
    end
  end

  always_comb begin
    case (regReq.addr)
      `OFF_STATUS:  rd_nxt = statusWord;
      `OFF_ACCA_LO: rd_nxt = acc_r[0][15:0];
      `OFF_ACCA_HI: rd_nxt = acc_r[0][31:16];
      `OFF_ACCA_UP: rd_nxt = {8'h00, acc_r[0][39:32]};
      `OFF_ACCB_LO: rd_nxt = acc_r[1][15:0];
      `OFF_ACCB_HI: rd_nxt = acc_r[1][31:16];
      `OFF_ACCB_UP: rd_nxt = {8'h00, acc_r[1][39:32]};
      `OFF_PC:      rd_nxt = pc_r;
      `OFF_CYCLES:  rd_nxt = cyc_r;
      default:      rd_nxt = regReq.addr[4] ? 16'h0000 : w_r[regReq.addr[3:0]];
    endcase
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rd_r <= 16'h0000;
    end else begin
      rd_r <= regReq.rd ? rd_nxt : 16'h0000;
    end
  end

  // helper copies of the last decode, read only by the checks
  logic [32:0] prodQ;
  logic [3:0]  dstQ;
  logic        accQ;
  always_ff @(posedge clock) begin
    prodQ <= prod;
    dstQ  <= ins.dst;
    accQ  <= ins.acc;
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  chk_dword_second: assert property ( // [RULE_04]
    exec && ins.cls == cpu_mul_pkg::OC_MOVD |=> state_r == cpu_mul_pkg::ST_WORD2 && !retire_r)
    else $error("double word did not wait for its second word");
  chk_lone_nop: assert property ( // [RULE_03]
    exec && ins.cls == cpu_mul_pkg::OC_NOP |=> $stable(statusWord) && !mem_r.en && retire_r)
    else $error("lone second word had an effect");
  chk_stall_quiet: assert property ( // [RULE_06]
    exec && ins.cls == cpu_mul_pkg::OC_BRA |=> !ready_r && !mem_r.en ##1 ready_r && retire_r)
    else $error("extra cycle was not a quiet no-op");
  chk_single_cycle: assert property ( // [RULE_05]
    exec && !multiCyc |=> ready_r && retire_r)
    else $error("single word took more than one cycle");
  chk_skip_taken: assert property ( // [RULE_07]
    exec && ins.cls == cpu_mul_pkg::OC_SKPZ && opA == 16'h0000 ##1 take |=> !retire_r && !skip_r)
    else $error("skipped word was executed");
  chk_full_pair: assert property ( // [RULE_08]
    exec && ins.cls == cpu_mul_pkg::OC_MULF && ins.dst != 4'hF |=>
      w_r[dstQ] == prodQ[15:0] && w_r[dstQ + 4'h1] == prodQ[31:16])
    else $error("full product pair wrong");
  chk_mul_flags: assert property ( // [RULE_13]
    exec && isMul |=> $stable(statusWord) && retire_r)
    else $error("multiply changed a status flag");
  chk_acc_load: assert property ( // [RULE_11]
    exec && ins.cls == cpu_mul_pkg::OC_MULA |=> acc_r[accQ] == {{7{prodQ[32]}}, prodQ})
    else $error("accumulator not loaded with product");
  chk_awb_step: assert property ( // [RULE_16]
    exec && ins.cls == cpu_mul_pkg::OC_AWB && ins.awbInd |=>
      mem_r.en && w_r[`AWB_REG] == mem_r.addr + `AWB_STEP)
    else $error("writeback pointer not bumped");

  cov_full_mul: cover property (exec && ins.cls == cpu_mul_pkg::OC_MULF);
  cov_skip_dword: cover property (skip_r && take && ins.cls == cpu_mul_pkg::OC_MOVD);
  cov_saturate: cover property (exec && ins.cls == cpu_mul_pkg::OC_ASHF && shOvf);
endmodule

/* File: test_cpu_multiply_and_cycle_timing.sv */
// self-checking bench for the multiply core and its instruction timing
module test_cpu_multiply_and_cycle_timing;
  timeunit 1ns;
  timeprecision 100ps;

  logic                  clock;
  logic                  rstn;
  cpu_mul_pkg::reg_req_t regReq;
  logic [15:0]           regRdData;
  logic                  instrValid;
  logic [23:0]           instrWord;
  logic                  instrReady;
  logic                  retirePulse;
  logic [15:0]           pcOut;
  cpu_mul_pkg::mem_wr_t  memWr;
  cpu_mul_pkg::mem_wr_t  mw;
  int                    errors;
  int                    cmp_count;
  int                    cyc;
  int                    rets;
  int                    mwn;
  int                    edges;
  logic [23:0]           q[$];
  logic [31:0]           p;
  logic [15:0]           p0;

  cpu_mul_core DUT (
    .clock       (clock),
    .rstn        (rstn),
    .regReq      (regReq),
    .regRdData   (regRdData),
    .instrValid  (instrValid),
    .instrWord   (instrWord),
    .instrReady  (instrReady),
    .retirePulse (retirePulse),
    .pcOut       (pcOut),
    .memWr       (memWr)
  );

  always #2 clock = ~clock;

  // whole run needs well under a thousand cycles
  always @(posedge clock) begin
    cyc++;
    if (retirePulse === 1'b1) rets++;
    if (memWr.en === 1'b1) begin
      mw = memWr;
      mwn++;
    end
    if (cyc > 5000) begin
      errors++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  function automatic logic [23:0] mk(cpu_mul_pkg::op_class_t c, logic [1:0] m, logic [3:0] d, logic [4:0] s,
                                     logic [3:0] b, logic [2:0] f);
    return {c, m, f, d, s, b};
  endfunction

  // operand reading per sign mode: bit1 base unsigned, bit0 source unsigned
  function automatic logic [31:0] prod(logic [1:0] m, logic [15:0] a, logic [15:0] b);
    logic signed [32:0] x;
    logic signed [32:0] y;
    logic signed [32:0] r;
    x = m[1] ? {17'h00000, a} : {{17{a[15]}}, a};
    y = m[0] ? {17'h00000, b} : {{17{b[15]}}, b};
    r = x * y;
    return r[31:0];
  endfunction

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clock);
    regReq <= '{wr: 1'b1, rd: 1'b0, addr: a, data: d};
    @(posedge clock);
    regReq <= '0;
  endtask

  task automatic rchk(input logic [4:0] a, input logic [15:0] e);
    @(posedge clock);
    regReq <= '{wr: 1'b0, rd: 1'b1, addr: a, data: 16'h0000};
    @(posedge clock);
    regReq <= '0;
    #1;
    chk({16'h0000, regRdData}, {16'h0000, e});
  endtask

  // words go back to back; edges counts clock edges until the last take
  task automatic run();
    int i;
    edges = 0;
    @(posedge clock);
    for (i = 0; i < q.size(); i++) begin
      instrValid <= 1'b1;
      instrWord  <= q[i];
      #1;
      while (instrReady !== 1'b1 && edges < 50) begin
        @(posedge clock);
        edges++;
        #1;
      end
      @(posedge clock);
      edges++;
    end
    instrValid <= 1'b0;
    q.delete();
  endtask

  task automatic t_regs();
    rchk(5'h10, 16'h0000);
    rchk(5'h17, 16'h0000);
    wr(5'h19, 16'hFFFF);
    rchk(5'h19, 16'h0000);
    wr(5'h01, 16'hFFFE);
    wr(5'h02, 16'h8001);
    rchk(5'h01, 16'hFFFE);
  endtask

  task automatic t_mul();
    int m;
    wr(5'h10, 16'h0003);
    wr(5'h07, 16'h1234);
    for (m = 0; m < 4; m++) begin
      p = prod(2'(m), 16'hFFFE, 16'h8001);
      q.push_back(mk(cpu_mul_pkg::OC_MULF, 2'(m), 4'h4, 5'h02, 4'h1, 3'h0));
      run();
      chk(edges, 1);
      rchk(5'h04, p[15:0]);
      rchk(5'h05, p[31:16]);
      q.push_back(mk(cpu_mul_pkg::OC_PRODUCT_OP_LOW_WORD, 2'(m), 4'h6, 5'h02, 4'h1, 3'h0));
      run();
      rchk(5'h06, p[15:0]);
      rchk(5'h07, 16'h1234);
    end
    rchk(5'h10, 16'h0003);
  endtask

  task automatic t_lit_acc();
    // a signed reading of 0x1F would give +2 instead
    p = prod(2'h1, 16'hFFFE, 16'h001F);
    q.push_back(mk(cpu_mul_pkg::OC_MULF, 2'h0, 4'h8, 5'h1F, 4'h1, 3'h1));
    run();
    rchk(5'h08, p[15:0]);
    rchk(5'h09, p[31:16]);
    p = prod(2'h3, 16'hFFFE, 16'h8001);
    q.push_back(mk(cpu_mul_pkg::OC_MULA, 2'h3, 4'h0, 5'h02, 4'h1, 3'h4));
    run();
    rchk(5'h14, p[15:0]);
    rchk(5'h15, p[31:16]);
    rchk(5'h16, 16'h0000);
    rchk(5'h11, 16'h0000);
    p = prod(2'h1, 16'hFFFE, 16'h0005);
    q.push_back(mk(cpu_mul_pkg::OC_MULA, 2'h1, 4'h0, 5'h05, 4'h1, 3'h1));
    run();
    rchk(5'h11, p[15:0]);
    rchk(5'h12, p[31:16]);
  endtask

  task automatic t_words();
    q.push_back(mk(cpu_mul_pkg::OC_MOVD, 2'h0, 4'hA, 5'h00, 4'h0, 3'h0));
    q.push_back(24'h00BEEF);
    run();
    chk(edges, 2);
    rchk(5'h0A, 16'hBEEF);
    p0 = pcOut;
    q.push_back(24'h001A10);
    run();
    #1;
    chk({16'h0000, pcOut}, {16'h0000, p0 + 16'h0002});
    rchk(5'h0D, 16'h0000);
  endtask

  task automatic t_flow();
    int r0;
    wr(5'h03, 16'h0040);
    r0 = rets;
    q.push_back(mk(cpu_mul_pkg::OC_BRA, 2'h0, 4'h0, 5'h00, 4'h3, 3'h0));
    q.push_back(24'h000000);
    run();
    chk(edges, 3);
    #1;
    chk({16'h0000, pcOut}, 32'h00000042);
    rchk(5'h10, 16'h0003);
    chk(rets - r0, 2);
    wr(5'h10, 16'h0009);
    q.push_back(mk(cpu_mul_pkg::OC_SLOWRD, 2'h0, 4'hB, 5'h00, 4'h0, 3'h0));
    q.push_back(24'h000000);
    run();
    chk(edges, 3);
    rchk(5'h0B, 16'h0009);
  endtask

  task automatic t_skip();
    q.push_back(mk(cpu_mul_pkg::OC_SKPZ, 2'h0, 4'h0, 5'h00, 4'h0, 3'h0));
    q.push_back(mk(cpu_mul_pkg::OC_PRODUCT_OP_LOW_WORD, 2'h0, 4'hC, 5'h02, 4'h1, 3'h0));
    q.push_back(24'h000000);
    run();
    chk(edges, 3);
    rchk(5'h0C, 16'h0000);
    q.push_back(mk(cpu_mul_pkg::OC_SKPZ, 2'h0, 4'h0, 5'h00, 4'h0, 3'h0));
    q.push_back(mk(cpu_mul_pkg::OC_MOVD, 2'h0, 4'hC, 5'h00, 4'h0, 3'h0));
    q.push_back(24'h0000AA);
    q.push_back(24'h000000);
    run();
    chk(edges, 4);
    rchk(5'h0C, 16'h0000);
    p = prod(2'h0, 16'hFFFE, 16'h8001);
    q.push_back(mk(cpu_mul_pkg::OC_SKPZ, 2'h0, 4'h0, 5'h00, 4'h1, 3'h0));
    q.push_back(mk(cpu_mul_pkg::OC_PRODUCT_OP_LOW_WORD, 2'h0, 4'hC, 5'h02, 4'h1, 3'h0));
    run();
    rchk(5'h0C, p[15:0]);
  endtask

  task automatic t_misc();
    wr(5'h12, 16'h5A5A);
    wr(5'h0D, 16'h0100);
    q.push_back(mk(cpu_mul_pkg::OC_AWB, 2'h0, 4'h0, 5'h00, 4'h0, 3'h2));
    run();
    rchk(5'h0D, 16'h0102);
    chk({mw.addr, mw.data}, 32'h01005A5A);
    q.push_back(mk(cpu_mul_pkg::OC_AWB, 2'h0, 4'h0, 5'h00, 4'h0, 3'h0));
    run();
    rchk(5'h0D, 16'h5A5A);
    chk(mwn, 1);
    q.push_back(mk(cpu_mul_pkg::OC_BSET, 2'h0, 4'h0, 5'h0F, 4'hE, 3'h0));
    q.push_back(mk(cpu_mul_pkg::OC_BSET, 2'h0, 4'h0, 5'h10, 4'hE, 3'h0));
    run();
    rchk(5'h0E, 16'h8001);
    wr(5'h10, 16'h0000);
    wr(5'h09, 16'hFFFF);
    wr(5'h0A, 16'h0001);
    q.push_back(mk(cpu_mul_pkg::OC_ADD, 2'h0, 4'hB, 5'h0A, 4'h9, 3'h0));
    run();
    rchk(5'h0B, 16'h0000);
    rchk(5'h10, 16'h0103);
  endtask

  task automatic t_size_shift();
    wr(5'h0B, 16'hAB12);
    q.push_back(mk(cpu_mul_pkg::OC_ADD, 2'h1, 4'hB, 5'h0A, 4'h9, 3'h0));
    run();
    rchk(5'h0B, 16'hAB00);
    rchk(5'h10, 16'h0103);
    wr(5'h06, 16'h0001);
    wr(5'h07, 16'h0000);
    wr(5'h08, 16'hFFFF);
    wr(5'h09, 16'hFFFF);
    wr(5'h10, 16'h0000);
    // a zero double result must not set the sticky zero bit
    q.push_back(mk(cpu_mul_pkg::OC_ADD, 2'h2, 4'hC, 5'h08, 4'h6, 3'h0));
    run();
    rchk(5'h0D, 16'h0000);
    rchk(5'h10, 16'h0101);
    wr(5'h14, 16'h0001);
    wr(5'h15, 16'h0000);
    wr(5'h16, 16'h0000);
    wr(5'h0F, 16'h001F);
    wr(5'h10, 16'h0000);
    q.push_back(mk(cpu_mul_pkg::OC_ASHF, 2'h0, 4'h0, 5'h04, 4'h0, 3'h5));
    run();
    rchk(5'h14, 16'h0010);
    q.push_back(mk(cpu_mul_pkg::OC_ASHF, 2'h0, 4'h0, 5'h0F, 4'h0, 3'h4));
    run();
    rchk(5'h16, 16'h0008);
    rchk(5'h10, 16'h4000);
    q.push_back(mk(cpu_mul_pkg::OC_ASHF, 2'h0, 4'h0, 5'h1F, 4'h0, 3'h5));
    run();
    rchk(5'h16, 16'h007F);
    rchk(5'h10, 16'h5000);
    rchk(5'h13, 16'h00FF);
  endtask

  initial begin
    clock      = 1'b0;
    rstn       = 1'b0;
    regReq     = '0;
    instrValid = 1'b0;
    instrWord  = 24'h000000;
    errors     = 0;
    cmp_count  = 0;
    cyc        = 0;
    rets       = 0;
    mwn        = 0;
    mw         = '0;
    repeat (3) @(posedge clock);
    rstn <= 1'b1;
    t_regs();
    t_mul();
    t_lit_acc();
    t_words();
    t_flow();
    t_skip();
    t_misc();
    t_size_shift();
    stop_test();
  end
endmodule
